// ==== unwind_consts.svh ====
// Purpose: Constants for the exception frame unwinding block.
// Assumes: Byte-addressed stack, 16-bit stack bus words.
// Notes:   Definitions only.
`ifndef UNWIND_CONSTS_SVH
`define UNWIND_CONSTS_SVH
`define FMT_FOUR        4'h0
`define FMT_THROW       4'h1
`define FMT_SIX         4'h2
`define FMT_FPPOST      4'h3
`define FMT_EIGHT       4'h4
`define OFS_PC          32'h0000_0002
`define OFS_FMT         32'h0000_0006
`define OFS_EXTRA       32'h0000_0008
`define POP_FOUR        32'h0000_0008
`define POP_SIX         32'h0000_000c
`define SR_S_BIT        13
`define SR_M_BIT        12
`define SR_T0_BIT       14
`define SR_T1_BIT       15
`define VEC_FORMAT_ERR  12'h038
`define VEC_ADDR_ERR    12'h00c
`define VEC_FP_POST     12'h0c4
`endif

// ==== unwind_pkg.sv ====
// Purpose: Types for the exception frame unwinding block.
// Assumes: Nothing beyond the constants header.
// Notes:   States are one-hot.
package unwind_pkg;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_SR    = 8'h02,
    ST_PCH   = 8'h04,
    ST_PCL   = 8'h08,
    ST_FMT   = 8'h10,
    ST_ACT   = 8'h20,
    ST_TRAP  = 8'h40,
    ST_DONE  = 8'h80
  } unw_state_t;
  typedef enum logic [1:0] {
    STK_USER = 2'h0,
    STK_INT  = 2'h1,
    STK_MAST = 2'h2
  } stack_sel_t;
endpackage

// ==== stack_select.sv ====
// Purpose: Picks the active stack from a status word.
// Assumes: Status word bit layout from the constants header.
// Notes:   Registered output.
`timescale 1ns/10ps
`include "unwind_consts.svh"
module stack_select
  import unwind_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [15:0] status_word,
  output stack_sel_t       sel_ff
);
  // Supervisor and master bits choose among the three stacks.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_ff <= STK_INT;
    end else if (ce) begin
      if (!status_word[`SR_S_BIT]) begin
        sel_ff <= STK_USER;
      end else if (status_word[`SR_M_BIT]) begin
        sel_ff <= STK_MAST;
      end else begin
        sel_ff <= STK_INT;
      end
    end
  end
endmodule // stack_select

// ==== exception_frame_unwind.sv ====
// Purpose: Unwinds exception frames on an exception_return_instruction.
// Assumes: A word-wide stack read port answering with rd_valid.
// Notes:   Frame building for entry is reported as frame descriptors.
// Summary of operation
// - Format 0: load status word and PC, pop eight, resume.
// - Format 1: pop eight, load status word, restart return.
// - After throwaway, read new format from newly active stack.
// - Throwaway unwinding repeats for any format, any of three stacks.
// - Build throwaway frame on interrupt stack on master-to-interrupt.
// - Usual throwaway status word has S and M set.
// - Throwaway PC equals next-instruction PC on master stack.
// - Format 2: load status word and PC, pop twelve, resume.
// - Format 3: restore, pop twelve, take pending post exception.
// - Eight-word format 4 is neither created nor accepted.
// - Six-word: PC is next instruction, extra is cause address.
// - Address error: six-word frame, extra is reference minus one.
// - Four-word frames for listed exceptions; privilege saves first word.
// - Return examines frame on active supervisor stack for validity; code reads whichever stack S and M select, user stack included.
// - Odd PC with user trace causes address error, S set.
`timescale 1ns/10ps
`include "unwind_consts.svh"
module exception_frame_unwind
  import unwind_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        rte_start,
  input  wire logic [15:0] cur_status,
  input  wire logic [31:0] usp_in,
  input  wire logic [31:0] isp_in,
  input  wire logic [31:0] msp_in,
  input  wire logic        fp_post_pending,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data,
  input  wire logic        entry_req,
  input  wire logic [3:0]  entry_kind,
  input  wire logic [31:0] entry_next_pc,
  input  wire logic [31:0] entry_instr_pc,
  input  wire logic [31:0] entry_ea,
  input  wire logic        entry_m_to_i,
  output logic             rd_req,
  output logic [31:0]      rd_addr,
  output logic             busy,
  output logic             done,
  output logic [15:0]      new_status,
  output logic [31:0]      new_pc,
  output logic [31:0]      new_usp,
  output logic [31:0]      new_isp,
  output logic [31:0]      new_msp,
  output logic             exc_take,
  output logic [11:0]      exc_vector,
  output logic [15:0]      exc_status,
  output logic [31:0]      exc_pc,
  output logic             frame_valid,
  output logic [3:0]       frame_format,
  output logic [31:0]      frame_pc,
  output logic [31:0]      frame_extra,
  output logic             frame_throw,
  output logic [15:0]      frame_throw_sr,
  output logic [31:0]      frame_throw_pc
);
  // Entry kinds, encoded for the frame describer.
  localparam logic [3:0] K_PRIV = 4'h1;
  localparam logic [3:0] K_SIXW = 4'h2;
  localparam logic [3:0] K_ADDR = 4'h3;
  localparam logic [3:0] K_UNFP = 4'h4;
  localparam logic [3:0] K_FPPS = 4'h5;

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    unw_state_t  st;
    logic        bsy;
    logic        req;
    logic [31:0] addr;
    logic [15:0] sr;
    logic [31:0] pc;
    logic [3:0]  fmt;
    logic [31:0] usp;
    logic [31:0] isp;
    logic [31:0] msp;
    logic        done;
    logic        take;
    logic [11:0] vec;
    logic [15:0] xsr;
    logic [31:0] xpc;
    logic        fv;
    logic [3:0]  ff;
    logic [31:0] fpc;
    logic [31:0] fex;
    logic        ft;
    logic [15:0] fts;
    logic [31:0] ftp;
  } unw_t;

  unw_t        cur_ff;
  unw_t        nxt_ff;
  stack_sel_t  sel;

  // Active stack follows the status word being unwound.
  stack_select u_sel (
    .mclk        (mclk),
    .rst         (rst),
    .ce          (ce),
    .status_word (nxt_ff.sr),
    .sel_ff      (sel)
  );

  // Returns the stack pointer of the selected stack.
  function automatic logic [31:0] sp_of(input unw_t s, input stack_sel_t k);
    case (k)
      STK_USER: sp_of = s.usp;
      STK_MAST: sp_of = s.msp;
      default:  sp_of = s.isp;
    endcase
  endfunction

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    logic [31:0] sp;
    logic [31:0] pop;
    nxt_ff      = cur_ff;
    sp          = sp_of(cur_ff, sel);
    pop         = `POP_FOUR;
    nxt_ff.done = 1'b0;
    nxt_ff.take = 1'b0;
    nxt_ff.fv   = 1'b0;
    case (cur_ff.st)
      ST_IDLE: begin
        if (rte_start) begin
          nxt_ff.sr  = cur_status;
          nxt_ff.usp = usp_in;
          nxt_ff.isp = isp_in;
          nxt_ff.msp = msp_in;
          nxt_ff.st  = ST_FMT;
        end
      end
      ST_FMT: begin
        // Format word sits at byte six of the active frame.
        nxt_ff.req  = 1'b1;
        nxt_ff.addr = sp + `OFS_FMT;
        if (cur_ff.req && rd_valid) begin
          nxt_ff.req = 1'b0;
          nxt_ff.fmt = rd_data[15:12];
          nxt_ff.st  = ST_SR;
        end
      end
      ST_SR: begin
        nxt_ff.req  = 1'b1;
        nxt_ff.addr = sp;
        if (cur_ff.req && rd_valid) begin
          nxt_ff.req = 1'b0;
          nxt_ff.xsr = rd_data;
          nxt_ff.st  = ST_PCH;
        end
      end
      ST_PCH: begin
        nxt_ff.req  = 1'b1;
        nxt_ff.addr = sp + `OFS_PC;
        if (cur_ff.req && rd_valid) begin
          nxt_ff.req      = 1'b0;
          nxt_ff.pc[31:16] = rd_data;
          nxt_ff.st        = ST_PCL;
        end
      end
      ST_PCL: begin
        nxt_ff.req  = 1'b1;
        nxt_ff.addr = sp + `OFS_PC + 32'h0000_0002;
        if (cur_ff.req && rd_valid) begin
          nxt_ff.req      = 1'b0;
          nxt_ff.pc[15:0] = rd_data;
          nxt_ff.st       = ST_ACT;
        end
      end
      ST_ACT: begin
        case (cur_ff.fmt)
          `FMT_FOUR, `FMT_THROW: pop = `POP_FOUR;
          default:               pop = `POP_SIX;
        endcase
        case (sel)
          STK_USER: nxt_ff.usp = sp + pop;
          STK_MAST: nxt_ff.msp = sp + pop;
          default:  nxt_ff.isp = sp + pop;
        endcase
        nxt_ff.sr = cur_ff.xsr;
        case (cur_ff.fmt)
          `FMT_THROW: nxt_ff.st = ST_FMT;
          `FMT_FOUR, `FMT_SIX: nxt_ff.st = ST_DONE;
          `FMT_FPPOST: begin
            // Pending post exception starts at once.
            if (fp_post_pending) begin
              nxt_ff.vec = `VEC_FP_POST;
              nxt_ff.st  = ST_TRAP;
            end else begin
              nxt_ff.st = ST_DONE;
            end
          end
          default: begin
            // Unknown and eight-word formats abandon the return.
            nxt_ff.sr  = cur_ff.sr;
            nxt_ff.usp = cur_ff.usp;
            nxt_ff.isp = cur_ff.isp;
            nxt_ff.msp = cur_ff.msp;
            nxt_ff.pc  = cur_pc_keep(cur_ff);
            nxt_ff.vec = `VEC_FORMAT_ERR;
            nxt_ff.st  = ST_TRAP;
          end
        endcase
        // Odd PC with trace enabled turns into an address error.
        if ((cur_ff.fmt inside {`FMT_FOUR, `FMT_SIX, `FMT_FPPOST})
            && cur_ff.pc[0]
            && (cur_ff.xsr[`SR_T0_BIT] || cur_ff.xsr[`SR_T1_BIT])) begin
          nxt_ff.vec = `VEC_ADDR_ERR;
          nxt_ff.st  = ST_TRAP;
        end
      end
      ST_TRAP: begin
        nxt_ff.take = 1'b1;
        nxt_ff.xsr  = cur_ff.sr | (16'h0001 << `SR_S_BIT);
        nxt_ff.xpc  = cur_ff.pc;
        nxt_ff.st   = ST_IDLE;
      end
      ST_DONE: begin
        nxt_ff.done = 1'b1;
        nxt_ff.st   = ST_IDLE;
      end
      default: nxt_ff.st = ST_IDLE;
    endcase

    // Describe the frame to build on exception entry.
    if (entry_req) begin
      nxt_ff.fv  = 1'b1;
      nxt_ff.ft  = entry_m_to_i;
      nxt_ff.fts = cur_status;
      nxt_ff.ftp = entry_next_pc;
      case (entry_kind)
        K_SIXW: begin
          nxt_ff.ff  = `FMT_SIX;
          nxt_ff.fpc = entry_next_pc;
          nxt_ff.fex = entry_instr_pc;
        end
        K_UNFP: begin
          nxt_ff.ff  = `FMT_SIX;
          nxt_ff.fpc = entry_next_pc;
          nxt_ff.fex = entry_ea;
        end
        K_ADDR: begin
          nxt_ff.ff  = `FMT_SIX;
          nxt_ff.fpc = entry_instr_pc;
          nxt_ff.fex = entry_ea - 32'h0000_0001;
        end
        K_FPPS: begin
          nxt_ff.ff  = `FMT_FPPOST;
          nxt_ff.fpc = entry_next_pc;
          nxt_ff.fex = entry_ea;
        end
        K_PRIV: begin
          nxt_ff.ff  = `FMT_FOUR;
          nxt_ff.fpc = entry_instr_pc;
          nxt_ff.fex = 32'h0000_0000;
        end
        default: begin
          nxt_ff.ff  = `FMT_FOUR;
          nxt_ff.fpc = entry_next_pc;
          nxt_ff.fex = 32'h0000_0000;
        end
      endcase
    end
    // Busy is registered so that the port leaves a flip-flop directly.
    nxt_ff.bsy = (nxt_ff.st != ST_IDLE);
  end

  // Keeps the PC read from the frame of a rejected return.
  function automatic logic [31:0] cur_pc_keep(input unw_t s);
    cur_pc_keep = s.pc;
  endfunction

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_ff    <= '0;
      cur_ff.st <= ST_IDLE;
    end else if (ce) begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs come straight from the state register.
  assign rd_req         = cur_ff.req;
  assign rd_addr        = cur_ff.addr;
  assign busy           = cur_ff.bsy;
  assign done           = cur_ff.done;
  assign new_status     = cur_ff.sr;
  assign new_pc         = cur_ff.pc;
  assign new_usp        = cur_ff.usp;
  assign new_isp        = cur_ff.isp;
  assign new_msp        = cur_ff.msp;
  assign exc_take       = cur_ff.take;
  assign exc_vector     = cur_ff.vec;
  assign exc_status     = cur_ff.xsr;
  assign exc_pc         = cur_ff.xpc;
  assign frame_valid    = cur_ff.fv;
  assign frame_format   = cur_ff.ff;
  assign frame_pc       = cur_ff.fpc;
  assign frame_extra    = cur_ff.fex;
  assign frame_throw    = cur_ff.ft;
  assign frame_throw_sr = cur_ff.fts;
  assign frame_throw_pc = cur_ff.ftp;

endmodule // exception_frame_unwind

// ==== unwind_asserts.sv ====
// Purpose: Port assertions for the frame unwinding block.
// Assumes: ce is held high.
// Notes:   Bound to the block after the module.
`timescale 1ns/10ps
module unwind_asserts (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        rte_start,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        exc_take,
  input wire logic [15:0] exc_status,
  input wire logic        rd_req,
  input wire logic        rd_valid,
  input wire logic [31:0] rd_addr,
  input wire logic        entry_req,
  input wire logic [3:0]  entry_kind,
  input wire logic [31:0] entry_ea,
  input wire logic [31:0] entry_instr_pc,
  input wire logic        frame_valid,
  input wire logic [3:0]  frame_format,
  input wire logic [31:0] frame_pc,
  input wire logic [31:0] frame_extra
);
  // ****************
  // Checks
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_exc_super: assert property (exc_take |-> exc_status[13])
    else $error("exception status lacks S");
  a_one_outcome: assert property (!(done && exc_take))
    else $error("done and exception together");
  a_read_hold: assert property (rd_req && !rd_valid |=>
    rd_req && $stable(rd_addr))
    else $error("read dropped early");
  a_start_busy: assert property (ce && rte_start && !busy |=> busy)
    else $error("return not started");
  a_end_bound: assert property ($rose(busy) |->
    ##[1:600] (done || exc_take))
    else $error("return never ended");
  a_frame_time: assert property (entry_req |=> frame_valid)
    else $error("no frame descriptor");
  a_priv_pc: assert property (entry_req && entry_kind == 4'h1 |=>
    frame_pc == $past(entry_instr_pc) && frame_format == 4'h0)
    else $error("privilege frame wrong");
  a_addr_extra: assert property (entry_req && entry_kind == 4'h3 |=>
    frame_extra == $past(entry_ea) - 32'h1)
    else $error("address error extra wrong");
endmodule // unwind_asserts
bind exception_frame_unwind unwind_asserts u_chk (.mclk, .rst, .ce,
  .rte_start, .busy, .done, .exc_take, .exc_status, .rd_req, .rd_valid,
  .rd_addr, .entry_req, .entry_kind, .entry_ea, .entry_instr_pc,
  .frame_valid, .frame_format, .frame_pc, .frame_extra);

// ==== exception_frame_unwind_tb.sv ====
// Purpose: Self-checking bench for the frame unwinding block.
// Assumes: ce high; stack memory is modelled here.
// Notes:   A frame walker predicts every return.
`timescale 1ns/10ps
module exception_frame_unwind_tb;
  logic        mclk = 1'b0, rst = 1'b1, ce = 1'b1, rte_start = 1'b0;
  logic        fp_post_pending = 1'b0, rd_valid = 1'b0, entry_req = 1'b0;
  logic        entry_m_to_i = 1'b0;
  logic [15:0] cur_status = 16'h0, rd_data = 16'h0;
  logic [31:0] usp_in = 32'h1000, isp_in = 32'h2000, msp_in = 32'h3000;
  logic [31:0] entry_next_pc = '0, entry_instr_pc = '0, entry_ea = '0;
  logic [3:0]  entry_kind = 4'h0, frame_format;
  logic        rd_req, busy, done, exc_take, frame_valid, frame_throw;
  logic [31:0] rd_addr, new_pc, new_usp, new_isp, new_msp;
  logic [31:0] frame_pc, frame_extra, frame_throw_pc, e_pc, exc_pc;
  logic [15:0] new_status, exc_status, e_st, frame_throw_sr;
  logic [11:0] exc_vector, e_vec;
  logic [15:0] mem [logic [31:0]];
  logic [31:0] e_sp [3];
  integer      seed = 13181, r, rr, n, s, fails = 0, total_checks = 0;
  integer      cyc = 0;
  // ****************
  // Device and stack memory
  // ****************
  exception_frame_unwind DUT (.mclk, .rst, .ce, .rte_start, .cur_status,
    .usp_in, .isp_in, .msp_in, .fp_post_pending, .rd_valid, .rd_data,
    .entry_req, .entry_kind, .entry_next_pc, .entry_instr_pc, .entry_ea,
    .entry_m_to_i, .rd_req, .rd_addr, .busy, .done, .new_status, .new_pc,
    .new_usp, .new_isp, .new_msp, .exc_take, .exc_vector, .exc_status,
    .exc_pc, .frame_valid, .frame_format, .frame_pc, .frame_extra,
    .frame_throw, .frame_throw_sr, .frame_throw_pc);
  always #12.5 mclk = ~mclk;
  // Reads are answered after a random wait; idle data keeps toggling.
  always @(posedge mclk) begin
    rr = $random(seed);
    rd_valid <= rd_req && !rd_valid && rr[0];
    rd_data <= (rd_req && !rd_valid && rr[0]) ? mem[rd_addr] : ~rd_data;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [31:0] a, input logic [15:0] sr,
                     input logic [31:0] pc, input logic [15:0] fw);
    mem[a] = sr;
    mem[a + 2] = pc[31:16];
    mem[a + 4] = pc[15:0];
    mem[a + 6] = fw;
  endtask
  // Walks the frames as the return must, from the given status word.
  task automatic model(input logic [15:0] st, input logic fp);
    logic [31:0] pc;
    logic [15:0] sr, fw;
    int k;
    e_sp = '{usp_in, isp_in, msp_in};
    e_vec = 12'h0;
    for (int i = 0; i < 8; i++) begin
      k = !st[13] ? 0 : st[12] ? 2 : 1;
      fw = mem[e_sp[k] + 6];
      sr = mem[e_sp[k]];
      pc = {mem[e_sp[k] + 2], mem[e_sp[k] + 4]};
      if (fw[15:12] > 4'h3) begin
        e_vec = 12'h038;
        break;
      end
      e_sp[k] += (fw[15:12] > 4'h1) ? 12 : 8;
      st = sr;
      if (fw[15:12] != 4'h1) begin
        if (pc[0] && sr[15:14] != 2'h0) e_vec = 12'h00c;
        else if (fw[15:12] == 4'h3 && fp) e_vec = 12'h0c4;
        break;
      end
    end
    e_st = st;
    e_pc = pc;
  endtask
  task automatic exception_return_instruction(input logic [15:0] st, input logic fp);
    model(st, fp);
    @(posedge mclk);
    cur_status <= st;
    fp_post_pending <= fp;
    rte_start <= 1'b1;
    @(posedge mclk);
    rte_start <= 1'b0;
    for (int w = 0; w < 600 && !(done | exc_take); w++) begin
      @(posedge mclk);
      #1;
    end
    chk(exc_take, e_vec != 12'h0);
    chk(done, e_vec == 12'h0);
    chk(busy, 1'b0);
    if (e_vec != 12'h0) begin
      chk(exc_vector, e_vec);
      chk(exc_status, e_st | 16'h2000);
      chk(exc_pc, e_pc);
    end else begin
      chk(new_status, e_st);
      chk(new_pc, e_pc);
      chk(new_usp, e_sp[0]);
      chk(new_isp, e_sp[1]);
      chk(new_msp, e_sp[2]);
    end
  endtask
  task automatic ent(input logic [3:0] k);
    @(posedge mclk);
    entry_kind <= k;
    entry_next_pc <= $random(seed);
    entry_instr_pc <= $random(seed);
    entry_ea <= $random(seed);
    entry_m_to_i <= k[0];
    entry_req <= 1'b1;
    @(posedge mclk);
    entry_req <= 1'b0;
    #1;
    chk(frame_valid, 1'b1);
    chk(frame_throw, entry_m_to_i);
    chk(frame_throw_sr, cur_status);
    chk(frame_throw_pc, entry_next_pc);
    chk(frame_format, k == 5 ? 3 : (k > 1 && k < 5) ? 2 : 0);
    if (k == 1 || k == 3) chk(frame_pc, entry_instr_pc);
    if (k == 2 || k == 4) chk(frame_pc, entry_next_pc);
    if (k == 2) chk(frame_extra, entry_instr_pc);
    if (k == 3) chk(frame_extra, entry_ea - 32'h1);
    if (k == 4) chk(frame_extra, entry_ea);
  endtask
  task automatic end_sim();
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    put(32'h2000, 16'h0004, 32'h1234, 16'h0018);
    exception_return_instruction(16'h2000, 1'b0);
    put(32'h2000, 16'h8000, 32'h1235, 16'h0018);
    exception_return_instruction(16'h2000, 1'b0);
    // Throwaway chain across interrupt, master and user stacks.
    put(32'h2000, 16'h3000, 32'h4000, 16'h1040);
    put(32'h3000, 16'h0000, 32'h4000, 16'h1040);
    put(32'h1000, 16'h0011, 32'h5000, 16'h2024);
    exception_return_instruction(16'h2000, 1'b0);
    for (n = 0; n < 14; n++) begin
      put(32'h3000, 16'h3000, 32'h6000, {n[3:0] + 4'h2, 12'h0});
      exception_return_instruction(16'h3000, n[0]);
    end
    // Random frames on every stack, one spare frame above the interrupt-stack frame.
    for (n = 0; n < 30; n++) begin
      for (s = 0; s < 3; s++) begin
        r = $random(seed);
        put(32'h1000 * (s + 1), $random(seed), $random(seed),
            {2'h0, (r[1:0] == 2'h1 && s != 1) ? 2'h0 : r[1:0], 12'h0});
      end
      put(32'h2008, $random(seed), $random(seed), 16'h0);
      exception_return_instruction({2'h0, 1'b1, r[4], 12'h000}, r[5]);
    end
    for (n = 0; n < 8; n++) ent(n[3:0]);
    end_sim();
  end
endmodule // exception_frame_unwind_tb
